// ===== hdl/vector_master.sv
// Test vector bus master: turns tester request pins into bus transfers.
// Assumes the bus and its responses run on ref_clk_in and the tester
// samples the acknowledge on the rising edge of its own test clock.
`default_nettype none

module vector_master (
    // Bus clock and resets
    input wire logic ref_clk_in,
    input wire logic srst_in,
    input wire logic bus_reset_n_in,
    // Tester link
    input wire logic external_test_clock_in,
    input wire logic vector_req_a_in,
    input wire logic vector_req_b_in,
    output logic vector_ack_out,
    // Arbitration
    output logic test_bus_request_out,
    input wire logic test_bus_grant_in,
    // Slave responses
    input wire logic wait_in,
    input wire logic error_in,
    input wire logic last_in,
    // Bus data input and bus master outputs
    input wire logic [vector_master_pkg::DATA_WIDTH-1:0] bus_data_in,
    output logic [vector_master_pkg::DATA_WIDTH-1:0] addr_out,
    output logic [1:0] trans_type_out,
    output logic [1:0] size_out,
    output logic [1:0] prot_out,
    output logic write_out,
    // External port unit controls
    output logic in_enable_n_out,
    output logic out_enable_n_out,
    output logic out_latch_open_n_out,
    output logic test_active_out
);
    import vector_master_pkg::*;

    logic rst_all;
    logic req_a_meta_reg;
    logic req_a_sync_reg;
    logic req_b_meta_reg;
    logic req_b_sync_reg;
    mode_t state_reg;
    mode_t state_next;
    kind_t xfer_kind_reg;
    kind_t last_kind_reg;
    kind_t vec_kind;
    logic [1:0] vec_code;
    logic retract;
    logic xfer_done;
    logic busy;
    logic accept;
    logic [DATA_WIDTH-1:0] addr_reg;
    logic [1:0] trans_type_reg;
    logic write_reg;
    logic in_enable_n_reg;
    logic out_enable_n_reg;
    logic out_latch_open_n_reg;
    logic ack_src_reg;
    logic link_rst_meta_reg;
    logic link_rst_reg;
    logic ack_meta_reg;
    logic ack_reg;

    ////////////////////////////////////////////////////////////////////////
    // Resets and pin synchronisers

    // Either reset returns the master to its default role
    assign rst_all = srst_in | ~bus_reset_n_in;

    // Request pins come from the tester, outside the bus clock domain
    always_ff @(posedge ref_clk_in) begin
        if (rst_all) begin
            req_a_meta_reg <= 1'b0;
            req_a_sync_reg <= 1'b0;
            req_b_meta_reg <= 1'b0;
            req_b_sync_reg <= 1'b0;
        end else begin
            req_a_meta_reg <= vector_req_a_in;
            req_a_sync_reg <= req_a_meta_reg;
            req_b_meta_reg <= vector_req_b_in;
            req_b_sync_reg <= req_b_meta_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Vector decode and transfer completion

    assign vec_code = {req_a_sync_reg, req_b_sync_reg};

    // Both-high after a data vector is a turn-around, not an address load
    always_comb begin
        case (vec_code)
            VEC_ADDR: begin
                if (last_kind_reg == KIND_WRITE ||
                    last_kind_reg == KIND_READ) begin
                    vec_kind = KIND_TURN;
                end else begin
                    vec_kind = KIND_ADDR;
                end
            end
            VEC_WRITE: vec_kind = KIND_WRITE;
            VEC_READ: vec_kind = KIND_READ;
            default: vec_kind = KIND_NONE;
        endcase
    end

    // Retraction repeats the transfer; an error alone still ends it
    assign retract = ~wait_in & error_in & last_in;
    assign xfer_done = (xfer_kind_reg != KIND_NONE) & ~wait_in & ~retract;
    assign busy = (xfer_kind_reg != KIND_NONE) & ~xfer_done;
    // A new vector is taken only once the previous transfer is over
    assign accept = (state_reg == ST_TEST) & ~busy;

    ////////////////////////////////////////////////////////////////////////
    // Mode state machine

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_DEFAULT: begin
                if (req_a_sync_reg) begin
                    state_next = ST_REQUEST;
                end
            end
            ST_REQUEST: begin
                if (vec_code == VEC_END) begin
                    state_next = ST_DEFAULT;
                end else if (test_bus_grant_in) begin
                    state_next = ST_TEST;
                end
            end
            ST_TEST: begin
                if (accept && vec_code == VEC_END) begin
                    state_next = ST_DEFAULT;
                end
            end
            default: state_next = ST_DEFAULT;
        endcase
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_all) begin
            state_reg <= ST_DEFAULT;
        end else begin
            state_reg <= state_next;
        end
    end

    // Request held from entry until end of test
    assign test_bus_request_out = (state_reg != ST_DEFAULT);
    assign test_active_out = (state_reg == ST_TEST);

    ////////////////////////////////////////////////////////////////////////
    // Transfer pipeline

    // The vector taken now becomes the transfer of the next cycle
    always_ff @(posedge ref_clk_in) begin
        if (rst_all) begin
            xfer_kind_reg <= KIND_NONE;
            last_kind_reg <= KIND_NONE;
        end else if (state_reg != ST_TEST) begin
            xfer_kind_reg <= KIND_NONE;
            last_kind_reg <= KIND_NONE;
        end else if (accept) begin
            xfer_kind_reg <= vec_kind;
            last_kind_reg <= vec_kind;
        end
    end

    // Type and direction are registered on the same edge as the transfer kind
    always_ff @(posedge ref_clk_in) begin
        if (rst_all) begin
            trans_type_reg <= TRAN_ADDR_ONLY;
            write_reg <= 1'b0;
        end else if (state_reg != ST_TEST) begin
            trans_type_reg <= TRAN_ADDR_ONLY;
            write_reg <= 1'b0;
        end else if (accept) begin
            if (vec_kind == KIND_WRITE || vec_kind == KIND_READ) begin
                trans_type_reg <= TRAN_SEQ;
            end else begin
                trans_type_reg <= TRAN_ADDR_ONLY;
            end
            write_reg <= (vec_kind == KIND_WRITE);
        end
    end

    // Only a completed address transfer moves the address; no increment
    always_ff @(posedge ref_clk_in) begin
        if (rst_all) begin
            addr_reg <= ADDR_RESET;
        end else if (xfer_kind_reg == KIND_ADDR && xfer_done) begin
            addr_reg <= bus_data_in;
        end
    end

    assign addr_out = addr_reg;
    assign trans_type_out = trans_type_reg;
    assign write_out = write_reg;
    assign size_out = SIZE_WORD;
    assign prot_out = PROT_SUPER;

    ////////////////////////////////////////////////////////////////////////
    // External port unit controls

    // Inbound path open for address and write transfers only
    always_ff @(posedge ref_clk_in) begin
        if (rst_all) begin
            in_enable_n_reg <= 1'b1;
            out_latch_open_n_reg <= 1'b1;
        end else if (state_reg != ST_TEST) begin
            in_enable_n_reg <= 1'b1;
            out_latch_open_n_reg <= 1'b1;
        end else if (accept) begin
            in_enable_n_reg <= ~(vec_kind == KIND_ADDR ||
                                 vec_kind == KIND_WRITE);
            out_latch_open_n_reg <= ~(vec_kind == KIND_READ);
        end
    end

    // Read data goes out in the cycle after its transfer ends
    always_ff @(posedge ref_clk_in) begin
        if (rst_all) begin
            out_enable_n_reg <= 1'b1;
        end else begin
            out_enable_n_reg <= ~(xfer_kind_reg == KIND_READ &&
                                  xfer_done);
        end
    end

    assign in_enable_n_out = in_enable_n_reg;
    assign out_enable_n_out = out_enable_n_reg;
    assign out_latch_open_n_out = out_latch_open_n_reg;

    ////////////////////////////////////////////////////////////////////////
    // Acknowledge toward the tester

    // Level is ready-for-vector; registered so the crossing sees no glitch
    always_ff @(posedge ref_clk_in) begin
        if (rst_all) begin
            ack_src_reg <= 1'b0;
        end else begin
            ack_src_reg <= (state_reg == ST_TEST) & ~busy;
        end
    end

    // Link side reset, brought into the test clock domain
    always_ff @(negedge external_test_clock_in) begin
        link_rst_meta_reg <= rst_all;
        link_rst_reg <= link_rst_meta_reg;
    end

    // Acknowledge changes only on the falling test clock edge
    always_ff @(negedge external_test_clock_in) begin
        if (link_rst_reg) begin
            ack_meta_reg <= 1'b0;
            ack_reg <= 1'b0;
        end else begin
            ack_meta_reg <= ack_src_reg;
            ack_reg <= ack_meta_reg;
        end
    end

    // Limitation: crossing delay adds two test clock falls of latency
    assign vector_ack_out = ack_reg;

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    // Grant while requesting leads to test mode
    property p_entry;
        @(posedge ref_clk_in) disable iff (rst_all)
        (state_reg == ST_REQUEST && test_bus_grant_in &&
         vec_code != VEC_END) |=> test_active_out;
    endproperty
    a_entry: assert property (p_entry)
        else $error("grant did not enter test mode");

    // Outside test only address-only transfers, never a write
    property p_default_idle;
        @(posedge ref_clk_in) disable iff (rst_all)
        !test_active_out |-> (trans_type_out == TRAN_ADDR_ONLY &&
                              !write_out && in_enable_n_out);
    endproperty
    a_default_idle: assert property (p_default_idle)
        else $error("transfer issued while default master");

    // Type limited to two codes, size and protection fixed
    property p_codes;
        @(posedge ref_clk_in) disable iff (rst_all)
        (trans_type_out == TRAN_ADDR_ONLY || trans_type_out == TRAN_SEQ)
        && size_out == SIZE_WORD && prot_out == PROT_SUPER;
    endproperty
    a_codes: assert property (p_codes)
        else $error("illegal transfer code");

    // A low pin takes two edges to reach the state machine
    property p_sync;
        @(posedge ref_clk_in) disable iff (rst_all)
        (!vector_req_a_in ##2 state_reg == ST_DEFAULT)
        |=> state_reg == ST_DEFAULT;
    endproperty
    a_sync: assert property (p_sync)
        else $error("request acted on before synchronisation");

    // Completed address transfer loads the data bus
    sequence s_addr_done;
        xfer_kind_reg == KIND_ADDR && xfer_done;
    endsequence
    property p_addr_load;
        @(posedge ref_clk_in) disable iff (rst_all)
        s_addr_done |=> addr_out == $past(bus_data_in);
    endproperty
    a_addr_load: assert property (p_addr_load)
        else $error("address not loaded");

    // Turn-around leaves the address alone
    property p_turn_hold;
        @(posedge ref_clk_in) disable iff (rst_all)
        xfer_kind_reg == KIND_TURN |=> $stable(addr_out);
    endproperty
    a_turn_hold: assert property (p_turn_hold)
        else $error("turn-around changed address");

    // Write transfer is sequential, writing, inbound path open
    property p_write;
        @(posedge ref_clk_in) disable iff (rst_all)
        xfer_kind_reg == KIND_WRITE |-> write_out &&
            trans_type_out == TRAN_SEQ && !in_enable_n_out;
    endproperty
    a_write: assert property (p_write)
        else $error("write transfer malformed");

    // Read value driven out in the following cycle
    sequence s_read_done;
        xfer_kind_reg == KIND_READ && xfer_done;
    endsequence
    property p_read_out;
        @(posedge ref_clk_in) disable iff (rst_all)
        s_read_done |=> !out_enable_n_out && in_enable_n_out == 1'b1;
    endproperty
    a_read_out: assert property (p_read_out)
        else $error("read data not driven out");

    // A waited transfer holds its kind and blocks the next vector
    property p_wait_hold;
        @(posedge ref_clk_in) disable iff (rst_all)
        (test_active_out && xfer_kind_reg != KIND_NONE && wait_in)
        |=> $stable(xfer_kind_reg) && !ack_src_reg;
    endproperty
    a_wait_hold: assert property (p_wait_hold)
        else $error("vector taken during wait");

    // End code leaves test mode at once
    property p_end;
        @(posedge ref_clk_in) disable iff (rst_all)
        (accept && vec_code == VEC_END) |=> !test_active_out &&
            trans_type_out == TRAN_ADDR_ONLY;
    endproperty
    a_end: assert property (p_end)
        else $error("end of test not honoured");

    // Bus reset drops test mode and acknowledge source
    property p_bus_reset;
        @(posedge ref_clk_in) disable iff (srst_in)
        !bus_reset_n_in |=> !test_active_out && !ack_src_reg;
    endproperty
    a_bus_reset: assert property (p_bus_reset)
        else $error("bus reset ignored");

endmodule // vector_master

`default_nettype wire

// ===== hdl/vector_master_pkg.sv
// Constants, encodings and state types of the test vector bus master.
// Assumes a single-edge bus model: one transfer slot per clock cycle.
`default_nettype none

package vector_master_pkg;

    // Transaction type encodings
    localparam logic [1:0] TRAN_ADDR_ONLY = 2'h0;
    localparam logic [1:0] TRAN_SEQ = 2'h3;

    // Word size and supervisor protection codes
    localparam logic [1:0] SIZE_WORD = 2'h2;
    localparam logic [1:0] PROT_SUPER = 2'h2;

    // Vector pin codes, {req_a, req_b}
    localparam logic [1:0] VEC_ADDR = 2'h3;
    localparam logic [1:0] VEC_WRITE = 2'h2;
    localparam logic [1:0] VEC_READ = 2'h1;
    localparam logic [1:0] VEC_END = 2'h0;

    // Address value after reset and bus data width
    localparam logic [31:0] ADDR_RESET = 32'h0000_0000;
    localparam int DATA_WIDTH = 32;

    // Kind of the transfer in flight
    typedef enum logic [2:0] {
        KIND_NONE,
        KIND_ADDR,
        KIND_TURN,
        KIND_WRITE,
        KIND_READ
    } kind_t;

    // Operating mode of the master
    typedef enum logic [1:0] {
        ST_DEFAULT,
        ST_REQUEST,
        ST_TEST
    } mode_t;

endpackage : vector_master_pkg

`default_nettype wire

// ===== sim/bus_side_model.sv
// Far side of the vector master: arbiter, 16-word slave, port unit.
// Assumes every bus signal runs on ref_clk_in; tester data comes from tb.
`default_nettype none

module bus_side_model
    import vector_master_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic srst_in,
    // Master outputs
    input wire logic test_bus_request_in,
    input wire logic [31:0] addr_in,
    input wire logic [1:0] trans_type_in,
    input wire logic write_in,
    input wire logic in_enable_n_in,
    input wire logic out_latch_open_n_in,
    // Tester drive of the test channel
    input wire logic [31:0] tester_data_in,
    // Responses
    output logic test_bus_grant_out,
    output logic wait_out,
    output logic [31:0] bus_data_out,
    output logic [31:0] read_latch_out
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [31:0] mem [16];
    logic [31:0] last_data = 32'h0;
    int wait_left = 0;
    int req_age = 0;

    ////////////////////////////////////////////////////////////////////////
    // Grant three cycles after request; this request outranks all others
    always @(posedge ref_clk_in) begin
        req_age <= (srst_in || !test_bus_request_in) ? 0 : req_age + 1;
    end
    assign test_bus_grant_out = test_bus_request_in && req_age >= 3;

    ////////////////////////////////////////////////////////////////////////
    // Waits come only from a loaded budget, so a stall is never endless
    assign wait_out = trans_type_in == TRAN_SEQ && wait_left > 0;
    always @(posedge ref_clk_in) begin
        if (wait_out) begin
            wait_left <= wait_left - 1;
        end else if (trans_type_in == TRAN_SEQ && write_in) begin
            mem[addr_in[5:2]] <= bus_data_out;
        end
        if (!out_latch_open_n_in) begin
            read_latch_out <= bus_data_out;
        end
        last_data <= bus_data_out;
    end

    // Undriven data bus shows the inverse of the old value, never a hold
    assign bus_data_out = !in_enable_n_in ? tester_data_in
        : !out_latch_open_n_in ? mem[addr_in[5:2]] : ~last_data;

    // Loads a number of wait cycles for the coming sequential transfers
    task automatic add_waits(input int n);
        wait_left = n;
    endtask
endmodule // bus_side_model

`default_nettype wire

// ===== sim/vector_master_tb.sv
// Self-checking bench for the test vector bus master.
// Assumes bus_side_model stands on the bus side; tb plays the tester.
`default_nettype none

module vector_master_tb
    import vector_master_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    localparam logic [31:0] A1 = 32'h1000_0008;
    localparam logic [31:0] A2 = 32'h1000_0010;
    localparam logic [31:0] D1 = 32'hA5C3_0F1E;
    localparam logic [31:0] D2 = 32'h5A3C_F0E1;

    logic ref_clk_in = 1'b0;
    logic link_clk = 1'b0;
    logic srst_in = 1'b1;
    logic bus_reset_n = 1'b1;
    logic req_a = 1'b0;
    logic req_b = 1'b0;
    logic [31:0] tester_data_channel = 32'h0;
    logic bus_err = 1'b0;
    logic bus_last = 1'b0;
    logic ack, request, grant, wait_s, in_en_n, out_en_n, latch_n, test_on, wr;
    logic [31:0] bus_data, addr, rd_latch;
    logic [1:0] trans, size, prot;
    int n_mismatch = 0;
    int num_checks = 0;

    ////////////////////////////////////////////////////////////////////////
    // Clocks: bus at 40 ns, link at 64 ns with an unrelated phase
    initial begin
        forever #20 ref_clk_in = ~ref_clk_in;
    end
    initial begin
        #7;
        forever #32 link_clk = ~link_clk;
    end

    // Slave error and last come from the bench to force a retraction
    vector_master i_dut (.ref_clk_in(ref_clk_in), .srst_in(srst_in),
        .bus_reset_n_in(bus_reset_n), .external_test_clock_in(link_clk),
        .vector_req_a_in(req_a), .vector_req_b_in(req_b),
        .vector_ack_out(ack), .test_bus_request_out(request),
        .test_bus_grant_in(grant), .wait_in(wait_s), .error_in(bus_err),
        .last_in(bus_last), .bus_data_in(bus_data), .addr_out(addr),
        .trans_type_out(trans), .size_out(size), .prot_out(prot),
        .write_out(wr), .in_enable_n_out(in_en_n),
        .out_enable_n_out(out_en_n), .out_latch_open_n_out(latch_n),
        .test_active_out(test_on));

    bus_side_model i_model (.ref_clk_in(ref_clk_in), .srst_in(srst_in),
        .test_bus_request_in(request), .addr_in(addr),
        .trans_type_in(trans), .write_in(wr), .in_enable_n_in(in_en_n),
        .out_latch_open_n_in(latch_n), .tester_data_in(tester_data_channel),
        .test_bus_grant_out(grant), .wait_out(wait_s),
        .bus_data_out(bus_data), .read_latch_out(rd_latch));

    ////////////////////////////////////////////////////////////////////////
    // Reporting and comparison
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_flag(input logic got, input logic exp);
        chk_word({31'h0, got}, {31'h0, exp});
    endtask

    task automatic chk_tran(input logic [1:0] exp);
        chk_word({30'h0, trans}, {30'h0, exp});
    endtask

    // Sample 1 ns after the edge so that the design's updates have landed
    task automatic tick();
        @(posedge ref_clk_in);
        #1;
    endtask

    // Bounded wait; running out of cycles ends the run as a failure
    task automatic wait_for(ref logic sig, input logic val, input int bound);
        for (int i = 0; i < bound && sig !== val; i++) begin
            tick();
        end
        if (sig !== val) begin
            chk_flag(sig, val);
            print_verdict();
        end
    endtask

    // Tester applies a vector; its channel value follows three edges later,
    // when the transfer runs behind the two-flop pin synchroniser, so the
    // repeats of the previous vector still see the previous value
    task automatic vec(input logic [1:0] code, input logic [31:0] data);
        @(posedge ref_clk_in);
        {req_a, req_b} <= code;
        repeat (3) @(posedge ref_clk_in);
        tester_data_channel <= data;
        #1;
    endtask

    // A turn-around with the inverse on the channel must keep the held address
    task automatic turn_around(input logic [31:0] held);
        vec(VEC_ADDR, ~held);
        wait_for(wr, 1'b0, 8);
        chk_tran(TRAN_ADDR_ONLY);
        @(posedge ref_clk_in);
        tester_data_channel <= held;
        #1;
        chk_word(addr, held);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_reset();
        tick();
        chk_flag(test_on, 1'b0);
        chk_flag(request, 1'b0);
        chk_tran(TRAN_ADDR_ONLY);
        chk_flag(wr, 1'b0);
        chk_word({29'h0, in_en_n, out_en_n, latch_n}, 32'h7);
        chk_word(addr, ADDR_RESET);
        chk_word({28'h0, size, prot}, {28'h0, SIZE_WORD, PROT_SUPER});
        repeat (4) tick();
        chk_flag(ack, 1'b0);
        $display("test reset done");
    endtask

    task automatic t_entry();
        @(posedge ref_clk_in);
        {req_a, req_b} <= VEC_ADDR;
        tester_data_channel <= A1;
        tick();
        chk_flag(request, 1'b0);
        wait_for(request, 1'b1, 6);
        chk_flag(test_on, 1'b0);
        wait_for(test_on, 1'b1, 8);
        chk_flag(grant, 1'b1);
        wait_for(ack, 1'b1, 16);
        chk_tran(TRAN_ADDR_ONLY);
        chk_word(addr, A1);
        $display("test entry done");
    endtask

    task automatic t_write_read();
        vec(VEC_WRITE, D1);
        wait_for(wr, 1'b1, 6);
        chk_tran(TRAN_SEQ);
        chk_flag(in_en_n, 1'b0);
        chk_word(addr, A1);
        turn_around(A1);
        chk_word(i_model.mem[A1[5:2]], D1);
        vec(VEC_READ, ~D1);
        wait_for(latch_n, 1'b0, 6);
        chk_tran(TRAN_SEQ);
        chk_flag(wr, 1'b0);
        chk_flag(in_en_n, 1'b1);
        chk_word(addr, A1);
        wait_for(out_en_n, 1'b0, 6);
        chk_word(rd_latch, D1);
        turn_around(A1);
        vec(VEC_ADDR, A2);
        repeat (4) tick();
        chk_word(addr, A2);
        $display("test write and read done");
    endtask

    task automatic t_wait();
        vec(VEC_WRITE, D2);
        i_model.add_waits(2);
        wait_for(wait_s, 1'b1, 6);
        chk_word(addr, A2);
        chk_flag(wr, 1'b1);
        wait_for(ack, 1'b0, 10);
        wait_for(ack, 1'b1, 20);
        turn_around(A2);
        chk_word(i_model.mem[A2[5:2]], D2);
        $display("test waited write done");
    endtask

    // Error with last retracts the transfer: the tester is held off
    task automatic t_retract();
        @(posedge ref_clk_in);
        {bus_err, bus_last} <= 2'h3;
        repeat (2) @(posedge ref_clk_in);
        {bus_err, bus_last} <= 2'h0;
        #1;
        wait_for(ack, 1'b0, 10);
        wait_for(ack, 1'b1, 20);
        chk_word(addr, A2);
        chk_flag(test_on, 1'b1);
        $display("test retraction done");
    endtask

    task automatic t_end();
        repeat (3) tick();
        vec(VEC_END, A2);
        wait_for(test_on, 1'b0, 8);
        chk_flag(request, 1'b0);
        wait_for(ack, 1'b0, 12);
        repeat (4) tick();
        chk_tran(TRAN_ADDR_ONLY);
        chk_flag(wr, 1'b0);
        $display("test end of test done");
    endtask

    task automatic t_bus_reset();
        vec(VEC_ADDR, A1);
        wait_for(test_on, 1'b1, 16);
        @(posedge ref_clk_in);
        bus_reset_n <= 1'b0;
        {req_a, req_b} <= VEC_END;
        repeat (2) tick();
        chk_flag(test_on, 1'b0);
        chk_flag(request, 1'b0);
        chk_word(addr, ADDR_RESET);
        @(posedge ref_clk_in);
        bus_reset_n <= 1'b1;
        wait_for(ack, 1'b0, 12);
        $display("test bus reset done");
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (2) @(posedge ref_clk_in);
        srst_in <= 1'b0;
        t_reset();
        t_entry();
        t_write_read();
        t_wait();
        t_retract();
        t_end();
        t_bus_reset();
        print_verdict();
    end
endmodule // vector_master_tb

`default_nettype wire
